/* File: cpp_pkg.sv */
/*
 * Constants for the charger power path control block.
 * Assumes one 125 MHz clock and register fields presented as plain ports.
 */
package cpp_pkg;
	localparam int CLK_MHZ = 125;
	localparam int BOOST_DELAY_MS = 30;
	localparam int BOOST_DELAY_CYC = BOOST_DELAY_MS * 1000 * CLK_MHZ;
	localparam int ALERT_PULSE_US = 256;
	localparam int ALERT_PULSE_CYC = ALERT_PULSE_US * CLK_MHZ;
	localparam int BLINK_HALF_MS = 500;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
	// Input limit codes (REG00[2:0])
	localparam logic [2:0] CURRENT_LIMIT_PIN_100MA = 3'h0;
	localparam logic [2:0] CURRENT_LIMIT_PIN_500MA = 3'h2;
	localparam logic [2:0] CURRENT_LIMIT_PIN_3A = 3'h7;
	// Source type codes (REG08[7:6])
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_USB = 2'h1;
	localparam logic [1:0] SRC_ADAPTER = 2'h2;
	localparam logic [1:0] SRC_STEPUP = 2'h3;
	// Charge configuration (REG01[5:4])
	localparam logic [1:0] CFG_CHARGE = 2'h1;
	localparam logic [1:0] CFG_STEPUP = 2'h2;
	// Step-up temperature window disabled code
	localparam logic [1:0] TEMP_WIN_OFF = 2'h3;
	// Charge phase (REG08[5:4])
	localparam logic [1:0] PH_DISABLED = 2'h0;
	localparam logic [1:0] PH_PRE = 2'h1;
	localparam logic [1:0] PH_FAST = 2'h2;
	localparam logic [1:0] PH_DONE = 2'h3;
	// Power-on charge defaults, mV / mA / hours
	localparam logic [12:0] DEF_CHG_MV = 13'h1070;
	localparam logic [12:0] DEF_CHG_MA = 13'h0800;
	localparam logic [12:0] DEF_PRE_MA = 13'h0080;
	localparam logic [12:0] DEF_TERM_MA = 13'h0100;
	localparam logic [3:0] DEF_TIMER_H = 4'hc;
	localparam logic [2:0] DEF_MINSYS = 3'h5;
	typedef enum logic [2:0] {
		CP_OFF, CP_HIZ, CP_DETECT, CP_RUN, CP_STEPUP
	} cpp_state_t;
	typedef enum logic [1:0] {
		CC_IDLE, CC_PRE, CC_FAST, CC_DONE
	} cpp_chg_t;
endpackage

/* File: cpp_charger_ctrl.sv */
/*
 * Power path and charge control sequencer of a single-cell charger.
 * Assumes analog comparators arrive as synchronous levels and that
 * register fields are held by a host-side register file outside.
 */
// What this block does
// - 100 mA host plus good battery enters high impedance, bias off, flag set.
// - In host mode high impedance stays until host clears the flag.
// - Default mode clears flag on source removal, redetects on next insertion.
// - Force write or watchdog timeout reruns detection at 100 mA, self-clears.
// - After limit set, converter on; with charge disabled the switch closes only for supplement.
// - Load rail below 2.2 V forces 100 mA, else lowest of register, pin and detected limit.
// - Step-up needs battery ok, sleep, pin and config, temperature, 30 ms.
// - Step-up reports 11 in source status, current limit from select bit.
// - Step-up level follows the four-bit level field.
// - A step-up fault while step-up is on sets the fault bit and alerts the host.
// - Minimum load rail voltage comes from a three-bit field, default 3.5 V.
// - Status bit set while load rail held at minimum voltage.
// - Overload when current or voltage limit exceeded; charge current reduced.
// - Status bit set while overload throttling is active.
// - When not charging, switch closes when rail below battery, opens below depletion threshold.
// - Charge starts only when converter runs, enabled, no faults, switch free.
// - Terminate on low current and high voltage; recharge below threshold.
// - Toggling the enable pin or configuration restarts charging after done.
// - Indicator low charging, high done or disabled, blinking on fault.
// - Charge phase encodes disabled, precharge, fast, done.
// - Host alert raised when a charge cycle completes.
// - Power-on defaults for voltage, currents and safety timer.
// - Each alert is one low pulse of 256 microseconds.
`timescale 1ns/10ps
`default_nettype none
module cpp_charger_ctrl #(
	// Step-up start delay in clock cycles
	parameter int BOOST_CYC = cpp_pkg::BOOST_DELAY_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Source and pins
	input wire logic srcPresent,
	input wire logic srcIsUsbHost,
	input wire logic stepUpEnablePin,
	input wire logic chargeEnablePinN,
	input wire logic hostMode,
	input wire logic watchdogTimeout,
	input wire logic [2:0] currentLimitPin,
	// Analog comparators
	input wire logic batAboveGood,
	input wire logic batAboveLow,
	input wire logic batAboveDepletion,
	input wire logic batAboveRecharge,
	input wire logic chargeBelowTerm,
	input wire logic inputInSleep,
	input wire logic loadRailAbove2v2,
	input wire logic loadRailBelowBat,
	input wire logic loadRailAtMin,
	input wire logic inCurOverLimit,
	input wire logic inVoltUnderLimit,
	input wire logic tempInStepUpWindow,
	input wire logic thermistorFault,
	input wire logic safetyTimerFault,
	input wire logic stepUpFault,
	// Register fields from host
	input wire logic hizClearWrite,
	input wire logic forceDetectWrite,
	input wire logic [2:0] regInputLimit,
	input wire logic [1:0] chargeConfig,
	input wire logic stepUpHighCurrent,
	input wire logic [3:0] stepUpLevelField,
	input wire logic [1:0] stepUpTempWindow,
	input wire logic [2:0] minRailField,
	input wire logic switchForceOff,
	input wire logic faultClear,
	// Status out
	output logic highImpedanceState,
	output logic forceDetectBusy,
	output logic [1:0] sourceStatus,
	output logic [1:0] chargePhase,
	output logic minRailStatus,
	output logic throttleStatus,
	output logic stepUpFaultBit,
	// Control out
	output logic biasRegulatorOn,
	output logic converterOn,
	output logic batterySwitchOn,
	output logic chargeReduce,
	output logic stepUpOn,
	output logic stepUpCurSel,
	output logic [3:0] stepUpLevel,
	output logic [2:0] minRailLevel,
	output logic [2:0] activeInputLimit,
	output logic [12:0] chargeVoltMv,
	output logic [12:0] chargeCurMa,
	output logic [12:0] preCurMa,
	output logic [12:0] termCurMa,
	output logic [3:0] safetyTimerH,
	// Pins out, open drain
	output logic chargeIndOut,
	output logic chargeIndOe,
	output logic hostAlertN
);
	import cpp_pkg::*;

	cpp_state_t state_reg, state_next;
	cpp_chg_t chg_reg, chg_next;
	logic [2:0] detLimit_reg;
	logic [31:0] boostCnt_reg;
	logic [15:0] alertCnt_reg;
	logic [31:0] blinkCnt_reg;
	logic blink_reg;
	logic cePrev_reg;
	logic [1:0] cfgPrev_reg;
	logic srcPrev_reg;
	logic stepFaultPrev_reg;

	function automatic logic [2:0] minLimit(input logic [2:0] a,
		input logic [2:0] b);
		minLimit = (a < b) ? a : b;
	endfunction

	wire srcInsert = srcPresent && !srcPrev_reg;
	wire [2:0] pinLimitUsb = stepUpEnablePin ? CURRENT_LIMIT_PIN_500MA : CURRENT_LIMIT_PIN_100MA;
	wire [2:0] pinLimit = srcIsUsbHost ? pinLimitUsb : CURRENT_LIMIT_PIN_3A;
	wire is100Host = srcIsUsbHost && !stepUpEnablePin;
	wire goHiz = is100Host && batAboveGood;
	wire forceDet = srcPresent && (forceDetectWrite || watchdogTimeout);
	wire chargeAllowed = (chargeConfig == CFG_CHARGE) && !chargeEnablePinN &&
		!thermistorFault && !safetyTimerFault && !switchForceOff;
	wire tempOk = tempInStepUpWindow || (stepUpTempWindow == TEMP_WIN_OFF);
	wire stepUpReq = batAboveLow && inputInSleep && stepUpEnablePin &&
		(chargeConfig == CFG_STEPUP) && tempOk;
	wire boostDelayDone = (boostCnt_reg >= BOOST_CYC);
	wire overload = inCurOverLimit || inVoltUnderLimit;
	wire toggled = (chargeEnablePinN != cePrev_reg) ||
		(chargeConfig != cfgPrev_reg);
	wire stepFaultEdge = stepUpFault && !stepFaultPrev_reg;
	wire chargeDoneEv = (chg_reg != CC_DONE) && (chg_next == CC_DONE);
	wire alertEv = chargeDoneEv || (stepFaultEdge && stepUpOn);
	wire chargeFault = thermistorFault || safetyTimerFault;
	wire running = (state_reg == CP_RUN);
	// Supplement closes the switch even with charging off
	wire supplement = loadRailBelowBat && batAboveDepletion;
	wire charging = (chg_reg == CC_PRE) || (chg_reg == CC_FAST);
	wire switchNext = !switchForceOff && running &&
		(charging || supplement);
	wire [2:0] limitNext = !loadRailAbove2v2 ? CURRENT_LIMIT_PIN_100MA :
		minLimit(minLimit(regInputLimit, currentLimitPin), detLimit_reg);
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CP_OFF: begin
				if (srcPresent && !inputInSleep) begin
					state_next = CP_DETECT;
				end else if (stepUpReq) begin
					state_next = CP_STEPUP;
				end
			end
			CP_HIZ: begin
				// Host mode waits for the host; default mode for removal
				if (hostMode && hizClearWrite) begin
					state_next = CP_DETECT;
				end else if (!hostMode && !srcPresent) begin
					state_next = CP_OFF;
				end
			end
			CP_DETECT: begin
				if (!srcPresent) begin
					state_next = CP_OFF;
				end else if (goHiz) begin
					state_next = CP_HIZ;
				end else begin
					state_next = CP_RUN;
				end
			end
			CP_RUN: begin
				if (!srcPresent) begin
					state_next = CP_OFF;
				end else if (forceDet || srcInsert) begin
					state_next = CP_DETECT;
				end
			end
			CP_STEPUP: begin
				if (!stepUpReq || srcPresent) begin
					state_next = CP_OFF;
				end
			end
			default: begin
				state_next = CP_OFF;
			end
		endcase
	end

	always_comb begin
		chg_next = chg_reg;
		case (chg_reg)
			CC_IDLE: begin
				if (running && chargeAllowed) begin
					chg_next = batAboveLow ? CC_FAST : CC_PRE;
				end
			end
			CC_PRE, CC_FAST: begin
				if (!running || !chargeAllowed) begin
					chg_next = CC_IDLE;
				end else if (chargeBelowTerm && batAboveRecharge && !overload) begin
					chg_next = CC_DONE;
				end else if (batAboveLow) begin
					chg_next = CC_FAST;
				end
			end
			CC_DONE: begin
				if (!running || toggled || !batAboveRecharge) begin
					chg_next = CC_IDLE;
				end
			end
			default: begin
				chg_next = CC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= CP_OFF;
			chg_reg <= CC_IDLE;
			detLimit_reg <= CURRENT_LIMIT_PIN_100MA;
			cePrev_reg <= 1'b1;
			cfgPrev_reg <= CFG_CHARGE;
			srcPrev_reg <= 1'b0;
			stepFaultPrev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			chg_reg <= chg_next;
			cePrev_reg <= chargeEnablePinN;
			cfgPrev_reg <= chargeConfig;
			srcPrev_reg <= srcPresent;
			stepFaultPrev_reg <= stepUpFault;
			if (state_reg == CP_DETECT) begin
				detLimit_reg <= pinLimit;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			boostCnt_reg <= 32'h0;
		end else if (!stepUpReq) begin
			boostCnt_reg <= 32'h0;
		end else if (!boostDelayDone) begin
			boostCnt_reg <= boostCnt_reg + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			alertCnt_reg <= 16'h0;
			hostAlertN <= 1'b1;
		end else if (alertEv) begin
			alertCnt_reg <= 16'(ALERT_PULSE_CYC - 1);
			hostAlertN <= 1'b0;
		end else if (alertCnt_reg != 16'h0) begin
			alertCnt_reg <= alertCnt_reg - 16'h1;
		end else begin
			hostAlertN <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			blinkCnt_reg <= 32'h0;
			blink_reg <= 1'b0;
		end else if (blinkCnt_reg >= 32'(BLINK_HALF_CYC - 1)) begin
			blinkCnt_reg <= 32'h0;
			blink_reg <= !blink_reg;
		end else begin
			blinkCnt_reg <= blinkCnt_reg + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			highImpedanceState <= 1'b0;
			forceDetectBusy <= 1'b0;
			sourceStatus <= SRC_NONE;
			chargePhase <= PH_DISABLED;
			minRailStatus <= 1'b0;
			throttleStatus <= 1'b0;
			stepUpFaultBit <= 1'b0;
			biasRegulatorOn <= 1'b0;
			converterOn <= 1'b0;
			batterySwitchOn <= 1'b0;
			chargeReduce <= 1'b0;
			stepUpOn <= 1'b0;
			stepUpCurSel <= 1'b0;
			stepUpLevel <= 4'h0;
			minRailLevel <= DEF_MINSYS;
			activeInputLimit <= CURRENT_LIMIT_PIN_100MA;
			chargeVoltMv <= DEF_CHG_MV;
			chargeCurMa <= DEF_CHG_MA;
			preCurMa <= DEF_PRE_MA;
			termCurMa <= DEF_TERM_MA;
			safetyTimerH <= DEF_TIMER_H;
			chargeIndOut <= 1'b0;
			chargeIndOe <= 1'b1;
		end else begin
			highImpedanceState <= (state_next == CP_HIZ);
			biasRegulatorOn <= (state_next != CP_HIZ) && srcPresent;
			forceDetectBusy <= (state_next == CP_DETECT) && forceDet;
			converterOn <= running;
			batterySwitchOn <= switchNext;
			activeInputLimit <= (state_reg == CP_DETECT) ? CURRENT_LIMIT_PIN_100MA :
				limitNext;
			if (stepUpOn) begin
				sourceStatus <= SRC_STEPUP;
			end else if (srcPresent) begin
				sourceStatus <= srcIsUsbHost ? SRC_USB : SRC_ADAPTER;
			end else begin
				sourceStatus <= SRC_NONE;
			end
			stepUpOn <= (state_reg == CP_STEPUP) && stepUpReq &&
				boostDelayDone;
			stepUpCurSel <= stepUpHighCurrent;
			stepUpLevel <= stepUpLevelField;
			minRailLevel <= minRailField;
			minRailStatus <= loadRailAtMin && converterOn;
			chargeReduce <= overload;
			throttleStatus <= overload && running;
			// Hardware set wins over a same-cycle clear
			if (stepFaultEdge && stepUpOn) begin
				stepUpFaultBit <= 1'b1;
			end else if (faultClear) begin
				stepUpFaultBit <= 1'b0;
			end
			case (chg_next)
				CC_PRE: chargePhase <= PH_PRE;
				CC_FAST: chargePhase <= PH_FAST;
				CC_DONE: chargePhase <= PH_DONE;
				default: chargePhase <= PH_DISABLED;
			endcase
			// Enable low drives the pin low; released reads high
			if (chargeFault) begin
				chargeIndOe <= blink_reg;
			end else begin
				chargeIndOe <= !((chg_next == CC_PRE) || (chg_next == CC_FAST));
			end
			chargeIndOut <= 1'b0;
		end
	end

	property p_alert_width;
		@(posedge clk) disable iff (!nrst)
		$fell(hostAlertN) |-> !hostAlertN [*8];
	endproperty
	a_alert_width: assert property (p_alert_width)
		else $error("alert pulse too short");

	property p_hiz_bias;
		@(posedge clk) disable iff (!nrst)
		highImpedanceState |-> !biasRegulatorOn;
	endproperty
	a_hiz_bias: assert property (p_hiz_bias)
		else $error("bias on in high impedance");

	property p_hiz_hold;
		@(posedge clk) disable iff (!nrst)
		(highImpedanceState && hostMode && !hizClearWrite) |=>
			highImpedanceState;
	endproperty
	a_hiz_hold: assert property (p_hiz_hold)
		else $error("left high impedance without host clear");

	property p_stepup_cond;
		@(posedge clk) disable iff (!nrst)
		$rose(stepUpOn) |-> $past(stepUpReq) && $past(boostDelayDone);
	endproperty
	a_stepup_cond: assert property (p_stepup_cond)
		else $error("step-up without conditions");

	property p_stepup_status;
		@(posedge clk) disable iff (!nrst)
		stepUpOn |=> sourceStatus == SRC_STEPUP;
	endproperty
	a_stepup_status: assert property (p_stepup_status)
		else $error("step-up status wrong");

	sequence s_fault_seen;
		stepFaultEdge && stepUpOn;
	endsequence
	property p_fault_alert;
		@(posedge clk) disable iff (!nrst)
		s_fault_seen |=> stepUpFaultBit && !hostAlertN;
	endproperty
	a_fault_alert: assert property (p_fault_alert)
		else $error("step-up fault not flagged");

	property p_throttle;
		@(posedge clk) disable iff (!nrst)
		(overload && running) |=> throttleStatus && chargeReduce;
	endproperty
	a_throttle: assert property (p_throttle)
		else $error("throttle status missing");

	property p_soft_limit;
		@(posedge clk) disable iff (!nrst)
		!loadRailAbove2v2 |=> activeInputLimit == CURRENT_LIMIT_PIN_100MA;
	endproperty
	a_soft_limit: assert property (p_soft_limit)
		else $error("limit not forced low");

	property p_done_alert;
		@(posedge clk) disable iff (!nrst)
		chargeDoneEv |=> chargePhase == PH_DONE && !hostAlertN;
	endproperty
	a_done_alert: assert property (p_done_alert)
		else $error("done without alert");
endmodule
`default_nettype wire

/* File: cpp_alert_mon.sv */
/*
 * Host side model: watches the host alert line and measures pulses.
 * Assumes the alert line is synchronous to clk and idles high.
 */
`timescale 1ns/10ps
`default_nettype none
module cpp_alert_mon (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Alert line
	input wire logic hostAlertN,
	// Results
	output logic [15:0] lastWidth,
	output logic [7:0] pulseCount
);
	logic [15:0] lowCnt_reg;
	// Width is latched at the rising edge, so a stuck line never counts
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lowCnt_reg <= 16'h0;
			lastWidth <= 16'h0;
			pulseCount <= 8'h0;
		end else if (!hostAlertN) begin
			lowCnt_reg <= lowCnt_reg + 16'h1;
		end else if (lowCnt_reg != 16'h0) begin
			lastWidth <= lowCnt_reg;
			pulseCount <= pulseCount + 8'h1;
			lowCnt_reg <= 16'h0;
		end
	end
endmodule
`default_nettype wire

/* File: tb_charger_power_path_control.sv */
/*
 * Self-checking bench of the charger power path control sequencer.
 * Assumes the sequencer answers any level change within a few cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_charger_power_path_control;
	import cpp_pkg::*;
	logic clk, nrst, srcPresent, srcIsUsbHost, stepUpEnablePin;
	logic chargeEnablePinN, hostMode, watchdogTimeout, batAboveGood;
	logic batAboveLow, batAboveDepletion, batAboveRecharge, chargeBelowTerm;
	logic inputInSleep, loadRailAbove2v2, loadRailBelowBat, loadRailAtMin;
	logic inCurOverLimit, inVoltUnderLimit, tempInStepUpWindow;
	logic thermistorFault, safetyTimerFault, stepUpFault, hizClearWrite;
	logic forceDetectWrite, stepUpHighCurrent, switchForceOff, faultClear;
	logic [2:0] currentLimitPin, regInputLimit, minRailField;
	logic [1:0] chargeConfig, stepUpTempWindow;
	logic [3:0] stepUpLevelField;
	logic highImpedanceState, forceDetectBusy, minRailStatus, throttleStatus;
	logic stepUpFaultBit, biasRegulatorOn, converterOn, batterySwitchOn;
	logic chargeReduce, stepUpOn, stepUpCurSel, chargeIndOut, chargeIndOe;
	logic hostAlertN;
	logic [1:0] sourceStatus, chargePhase;
	logic [3:0] stepUpLevel, safetyTimerH;
	logic [2:0] minRailLevel, activeInputLimit;
	logic [12:0] chargeVoltMv, chargeCurMa, preCurMa, termCurMa;
	logic [15:0] lastWidth;
	logic [7:0] pulseCount, seenPulses;
	int miscompares = 0;
	int num_checks = 0;
	bit sawBusy, sawLow;
	// Shortened step-up delay so the run stays short
	localparam int BOOST_TEST_CYC = 64;

	cpp_charger_ctrl #(.BOOST_CYC(BOOST_TEST_CYC)) u_dut (.clk(clk),
		.nrst(nrst), .srcPresent(srcPresent),
		.srcIsUsbHost(srcIsUsbHost), .stepUpEnablePin(stepUpEnablePin),
		.chargeEnablePinN(chargeEnablePinN), .hostMode(hostMode),
		.watchdogTimeout(watchdogTimeout), .currentLimitPin(currentLimitPin),
		.batAboveGood(batAboveGood), .batAboveLow(batAboveLow),
		.batAboveDepletion(batAboveDepletion),
		.batAboveRecharge(batAboveRecharge), .chargeBelowTerm(chargeBelowTerm),
		.inputInSleep(inputInSleep), .loadRailAbove2v2(loadRailAbove2v2),
		.loadRailBelowBat(loadRailBelowBat), .loadRailAtMin(loadRailAtMin),
		.inCurOverLimit(inCurOverLimit), .inVoltUnderLimit(inVoltUnderLimit),
		.tempInStepUpWindow(tempInStepUpWindow),
		.thermistorFault(thermistorFault), .safetyTimerFault(safetyTimerFault),
		.stepUpFault(stepUpFault), .hizClearWrite(hizClearWrite),
		.forceDetectWrite(forceDetectWrite), .regInputLimit(regInputLimit),
		.chargeConfig(chargeConfig), .stepUpHighCurrent(stepUpHighCurrent),
		.stepUpLevelField(stepUpLevelField),
		.stepUpTempWindow(stepUpTempWindow), .minRailField(minRailField),
		.switchForceOff(switchForceOff), .faultClear(faultClear),
		.highImpedanceState(highImpedanceState),
		.forceDetectBusy(forceDetectBusy), .sourceStatus(sourceStatus),
		.chargePhase(chargePhase), .minRailStatus(minRailStatus),
		.throttleStatus(throttleStatus), .stepUpFaultBit(stepUpFaultBit),
		.biasRegulatorOn(biasRegulatorOn), .converterOn(converterOn),
		.batterySwitchOn(batterySwitchOn), .chargeReduce(chargeReduce),
		.stepUpOn(stepUpOn), .stepUpCurSel(stepUpCurSel),
		.stepUpLevel(stepUpLevel), .minRailLevel(minRailLevel),
		.activeInputLimit(activeInputLimit), .chargeVoltMv(chargeVoltMv),
		.chargeCurMa(chargeCurMa), .preCurMa(preCurMa), .termCurMa(termCurMa),
		.safetyTimerH(safetyTimerH), .chargeIndOut(chargeIndOut),
		.chargeIndOe(chargeIndOe), .hostAlertN(hostAlertN));
	cpp_alert_mon u_mon (.clk(clk), .nrst(nrst), .hostAlertN(hostAlertN),
		.lastWidth(lastWidth), .pulseCount(pulseCount));

	initial clk = 1'b0;
	always #4 clk = ~clk;

	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask
	function automatic logic [2:0] lowerOf(input logic [2:0] a,
		input logic [2:0] b);
		return (a < b) ? a : b;
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Roughly 65k cycles of tests; the limit leaves margin
	initial begin
		#(8 * 90000);
		miscompares++;
		complete_run();
	end

	initial begin
		{srcPresent, srcIsUsbHost, stepUpEnablePin, hostMode} = 4'h0;
		{watchdogTimeout, batAboveGood, batAboveLow, batAboveRecharge} = 4'h0;
		{chargeBelowTerm, inputInSleep, loadRailAbove2v2} = 3'h0;
		{loadRailBelowBat, loadRailAtMin, inCurOverLimit} = 3'h0;
		{inVoltUnderLimit, tempInStepUpWindow, thermistorFault} = 3'h0;
		{safetyTimerFault, stepUpFault, hizClearWrite} = 3'h0;
		{forceDetectWrite, stepUpHighCurrent, switchForceOff} = 3'h0;
		{faultClear, currentLimitPin, regInputLimit} = 7'h0;
		{chargeConfig, stepUpTempWindow, stepUpLevelField} = 8'h0;
		minRailField = 3'h5;
		batAboveDepletion = 1'b1;
		chargeEnablePinN = 1'b0;
		nrst = 1'b0;
		void'($urandom(13));
		settle(16);
		check("chargeVoltMv", chargeVoltMv, 13'h1070);
		check("chargeCurMa", chargeCurMa, 13'h0800);
		check("preCurMa", preCurMa, 13'h0080);
		check("termCurMa", termCurMa, 13'h0100);
		check("safetyTimerH", safetyTimerH, 13'h000c);
		check("minRailLevel", minRailLevel, 13'h0005);
		check("chargeIndOut", chargeIndOut, 1'b0);
		nrst = 1'b1;
		// 100 mA host with a good battery, host mode
		{hostMode, srcIsUsbHost, batAboveGood, srcPresent} = 4'hf;
		settle(8);
		check("hiz entry", highImpedanceState, 1'b1);
		check("bias off", biasRegulatorOn, 1'b0);
		settle(40);
		check("hiz held", highImpedanceState, 1'b1);
		batAboveGood = 1'b0;
		hizClearWrite = 1'b1;
		settle(1);
		hizClearWrite = 1'b0;
		settle(8);
		check("hiz cleared", highImpedanceState, 1'b0);
		// Default mode: removal ends high impedance
		srcPresent = 1'b0;
		hostMode = 1'b0;
		batAboveGood = 1'b1;
		settle(8);
		srcPresent = 1'b1;
		settle(8);
		check("hiz again", highImpedanceState, 1'b1);
		srcPresent = 1'b0;
		settle(8);
		check("hiz removed", highImpedanceState, 1'b0);
		// Adapter, charging disabled
		{batAboveGood, srcIsUsbHost} = 2'h0;
		{loadRailAbove2v2, srcPresent} = 2'h3;
		settle(8);
		check("converterOn", converterOn, 1'b1);
		check("switch open", batterySwitchOn, 1'b0);
		loadRailBelowBat = 1'b1;
		settle(4);
		check("supplement on", batterySwitchOn, 1'b1);
		batAboveDepletion = 1'b0;
		settle(4);
		check("depleted off", batterySwitchOn, 1'b0);
		{loadRailBelowBat, batAboveDepletion} = 2'h1;
		for (int i = 0; i < 8; i++) begin
			regInputLimit = (i == 0) ? 3'h0 : 3'($urandom);
			currentLimitPin = (i == 1) ? 3'h7 : 3'($urandom);
			loadRailAbove2v2 = (i != 7);
			settle(6);
			check("activeInputLimit", activeInputLimit, loadRailAbove2v2 ?
				lowerOf(regInputLimit, currentLimitPin) : 3'h0);
		end
		{loadRailAbove2v2, regInputLimit, currentLimitPin} = 7'h7f;
		settle(6);
		sawBusy = 0;
		sawLow = 0;
		forceDetectWrite = 1'b1;
		settle(1);
		forceDetectWrite = 1'b0;
		repeat (12) begin
			sawBusy |= (forceDetectBusy === 1'b1);
			sawLow |= (activeInputLimit === CURRENT_LIMIT_PIN_100MA);
			settle(1);
		end
		check("detect busy seen", sawBusy, 1'b1);
		check("detect at 100mA", sawLow, 1'b1);
		settle(8);
		check("detect self clear", forceDetectBusy, 1'b0);
		check("limit after detect", activeInputLimit, CURRENT_LIMIT_PIN_3A);
		// Charging cycle
		{batAboveLow, chargeConfig} = {1'b1, CFG_CHARGE};
		settle(8);
		check("charging", chargePhase !== PH_DISABLED, 1'b1);
		check("ind low", chargeIndOe, 1'b0);
		check("switch closed", batterySwitchOn, 1'b1);
		switchForceOff = 1'b1;
		settle(8);
		check("forced off", chargePhase, PH_DISABLED);
		check("ind high off", chargeIndOe, 1'b1);
		switchForceOff = 1'b0;
		settle(8);
		seenPulses = pulseCount;
		{chargeBelowTerm, batAboveRecharge} = 2'h3;
		settle(8);
		check("done", chargePhase, PH_DONE);
		check("ind high done", chargeIndOe, 1'b1);
		repeat (33000) if (pulseCount == seenPulses) settle(1);
		check("done alert", pulseCount, seenPulses + 8'h1);
		check("alert width", lastWidth, 16'h7d00);
		{chargeBelowTerm, batAboveRecharge} = 2'h0;
		settle(8);
		check("recharge", chargePhase !== PH_DONE, 1'b1);
		{chargeBelowTerm, batAboveRecharge} = 2'h3;
		settle(8);
		chargeBelowTerm = 1'b0;
		chargeEnablePinN = 1'b1;
		settle(8);
		chargeEnablePinN = 1'b0;
		settle(8);
		check("toggle restart", chargePhase !== PH_DONE, 1'b1);
		for (int i = 0; i < 6; i++) begin
			{inCurOverLimit, inVoltUnderLimit, loadRailAtMin} = 3'($urandom);
			minRailField = 3'($urandom);
			settle(6);
			check("throttle", throttleStatus,
				inCurOverLimit | inVoltUnderLimit);
			check("reduce", chargeReduce,
				inCurOverLimit | inVoltUnderLimit);
			check("minRailStatus", minRailStatus, loadRailAtMin);
			check("minRailLevel", minRailLevel, minRailField);
		end
		// Step-up refused while the input is awake
		{stepUpEnablePin, chargeConfig} = {1'b1, CFG_STEPUP};
		settle(8);
		check("no step-up", stepUpOn, 1'b0);
		repeat (33000) if (hostAlertN !== 1'b1) settle(1);
		// Source gone, input asleep, battery inside the step-up window
		{srcPresent, inputInSleep, tempInStepUpWindow} = 3'h3;
		stepUpHighCurrent = 1'($urandom);
		stepUpLevelField = 4'($urandom);
		settle(8);
		check("step-up delay", stepUpOn, 1'b0);
		settle(BOOST_TEST_CYC);
		check("step-up on", stepUpOn, 1'b1);
		check("step-up status", sourceStatus, SRC_STEPUP);
		check("step-up current", stepUpCurSel, stepUpHighCurrent);
		check("step-up level", stepUpLevel, stepUpLevelField);
		stepUpFault = 1'b1;
		settle(4);
		check("fault bit", stepUpFaultBit, 1'b1);
		check("fault alert", hostAlertN, 1'b0);
		faultClear = 1'b1;
		settle(1);
		faultClear = 1'b0;
		settle(2);
		check("fault cleared", stepUpFaultBit, 1'b0);
		complete_run();
	end
endmodule
`default_nettype wire
